/* File: rtl/stdp_pkg.sv */
// Purpose: Shared constants and types for the serial transmit data port
// Assumes: 50 MHz system clock
// Notes:   Data rate is given as one less than the cycle count per oversample tick
package stdp_pkg;

  // ==========================================================
  // Packet format and pin select encodings
  localparam logic [1:0] STDP_FMT_NORMAL = 2'h0;
  localparam logic [1:0] STDP_FMT_SYNC   = 2'h1;
  localparam logic [1:0] STDP_FMT_ASYNC  = 2'h3;

  localparam logic [5:0] STDP_SEL_SERIAL_DATA = 6'h0C;
  localparam logic [5:0] STDP_SEL_SERIAL_CLK  = 6'h0B;
  localparam logic [5:0] STDP_SEL_HIGH_Z      = 6'h2E;

  // ==========================================================
  // Counts
  localparam int unsigned STDP_OVERSAMPLE     = 8;
  localparam int unsigned STDP_SYNC_LATENCY   = 8;
  localparam logic [15:0] STDP_RATE_DIV_RESET = 16'h0019;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [1:0] packet_format_select;
    logic [5:0] pin_a_signal_select;
    logic [5:0] pin_b_signal_select;
    logic [5:0] pin_c_signal_select;
    logic [15:0] rate_div;
  } stdp_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } stdp_pins_t;

endpackage

/* File: rtl/stdp_serial_tx_data_port.sv */
// Purpose: Raw serial transmit data input path (async and sync modes)
// Assumes: Pin and chip select inputs are asynchronous to clk_in
// Notes:   Output bit tx_bit_out feeds the modulator
`timescale 1ns/100ps
`default_nettype none

// Function
// - Format value 3 selects asynchronous mode
// - Async mode bypasses packet handling and Manchester
// - Transmit strobe makes pin A data input
// - Async output routed per pin select
// - Async input sampled at eight times rate
// - Format value 1 selects synchronous mode
// - Device drives bit clock; host data follows
// - Pin A becomes input while transmitting
// - Sync input to output latency eight bits
// - Pin B output valid only when deselected
module stdp_serial_tx_data_port
  import stdp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Configuration
  input  wire stdp_cfg_t  cfg_in,
  // Control from the radio controller
  input  wire logic       transmit_strobe_in,
  input  wire logic       tx_stop_in,
  input  wire logic       chip_select_low_n_in,
  // Pin A input side
  input  wire logic       pin_a_in,
  // Pin drive
  output logic            pin_a_out,
  output logic            pin_a_oe_out,
  output logic            pin_b_out,
  output logic            pin_b_oe_out,
  output logic            pin_c_out,
  output logic            pin_c_oe_out,
  // Modulator side
  output logic            tx_active_out,
  output logic            tx_bit_out,
  output logic            tx_bit_valid_out,
  output logic            packet_bypass_out
);

  // ==========================================================
  // Mode decode
  logic mode_async;
  logic mode_sync;
  assign mode_async = (cfg_in.packet_format_select == STDP_FMT_ASYNC);
  assign mode_sync  = (cfg_in.packet_format_select == STDP_FMT_SYNC);

  function automatic logic pin_route(input logic [5:0] sel, input logic data,
                                     input logic clk);
    case (sel)
      STDP_SEL_SERIAL_DATA: pin_route = data;
      STDP_SEL_SERIAL_CLK:  pin_route = clk;
      default:              pin_route = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Input synchronisers
  logic a_meta_q;
  logic a_sync_q;
  // Chip select idles high, deselected
  logic cs_meta_q;
  logic cs_sync_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      a_meta_q  <= 1'b0;
      a_sync_q  <= 1'b0;
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
    end else begin
      a_meta_q  <= pin_a_in;
      a_sync_q  <= a_meta_q;
      cs_meta_q <= chip_select_low_n_in;
      cs_sync_q <= cs_meta_q;
    end
  end

  // ==========================================================
  // Transmit state
  typedef enum logic [0:0] {STDP_IDLE, STDP_TX} stdp_state_t;
  stdp_state_t state_q;
  // Output copy of the state, kept in step with it
  logic        tx_active_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q     <= STDP_IDLE;
      tx_active_q <= 1'b0;
    end else begin
      case (state_q)
        STDP_IDLE: begin
          if (transmit_strobe_in && (mode_async || mode_sync)) begin
            state_q     <= STDP_TX;
            tx_active_q <= 1'b1;
          end
        end
        STDP_TX: begin
          if (tx_stop_in || !(mode_async || mode_sync)) begin
            state_q     <= STDP_IDLE;
            tx_active_q <= 1'b0;
          end
        end
        default: begin
          state_q     <= STDP_IDLE;
          tx_active_q <= 1'b0;
        end
      endcase
    end
  end
  logic active;
  assign active = (state_q == STDP_TX);

  // ==========================================================
  // Oversample tick divider, eight ticks per bit
  logic [15:0] div_q;
  logic [2:0]  phase_q;
  logic        tick;
  assign tick = active && (div_q == 16'h0000);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !active) begin
      div_q   <= STDP_RATE_DIV_RESET;
      phase_q <= 3'h0;
    end else if (tick) begin
      div_q   <= cfg_in.rate_div;
      phase_q <= phase_q + 3'h1;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  // ==========================================================
  // Bit clock and data capture
  logic       bit_clk_q;
  logic [7:0] delay_q;
  logic       async_bit_q;
  logic       bit_q;
  logic       bit_valid_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !active) begin
      bit_clk_q   <= 1'b0;
      delay_q     <= 8'h00;
      async_bit_q <= 1'b0;
      bit_q       <= 1'b0;
      bit_valid_q <= 1'b0;
    end else begin
      bit_valid_q <= 1'b0;
      if (tick) begin
        if (mode_async) begin
          async_bit_q <= a_sync_q;
          bit_q       <= a_sync_q;
          bit_valid_q <= 1'b1;
        end else begin
          // Clock high for phases 0 to 3, data taken at 3
          bit_clk_q <= (phase_q < 3'h4);
          if (phase_q == 3'h3) begin
            delay_q     <= {delay_q[6:0], a_sync_q};
            bit_q       <= delay_q[STDP_SYNC_LATENCY-1];
            bit_valid_q <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Pin drive registers
  logic a_q;
  logic a_oe_q;
  logic b_q;
  logic b_oe_q;
  logic c_q;
  logic c_oe_q;
  logic data_src;
  logic clk_src;
  assign data_src = mode_async ? async_bit_q : 1'b0;
  assign clk_src  = mode_sync ? bit_clk_q : 1'b0;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      a_q    <= 1'b0;
      a_oe_q <= 1'b0;
      b_q    <= 1'b0;
      b_oe_q <= 1'b0;
      c_q    <= 1'b0;
      c_oe_q <= 1'b0;
    end else begin
      a_q    <= pin_route(cfg_in.pin_a_signal_select, data_src, clk_src);
      // Pin A held as input one cycle behind the transmit state, so still driven in its first cycle
      a_oe_q <= !active && (cfg_in.pin_a_signal_select != STDP_SEL_HIGH_Z);
      b_q    <= pin_route(cfg_in.pin_b_signal_select, data_src, clk_src);
      b_oe_q <= cs_sync_q && (cfg_in.pin_b_signal_select != STDP_SEL_HIGH_Z);
      c_q    <= pin_route(cfg_in.pin_c_signal_select, data_src, clk_src);
      c_oe_q <= (cfg_in.pin_c_signal_select != STDP_SEL_HIGH_Z);
    end
  end

  logic bypass_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= mode_async || mode_sync;
    end
  end

  assign pin_a_out        = a_q;
  assign pin_a_oe_out     = a_oe_q;
  assign pin_b_out        = b_q;
  assign pin_b_oe_out     = b_oe_q;
  assign pin_c_out        = c_q;
  assign pin_c_oe_out     = c_oe_q;
  assign tx_active_out    = tx_active_q;
  assign tx_bit_out       = bit_q;
  assign tx_bit_valid_out = bit_valid_q;
  assign packet_bypass_out = bypass_q;

endmodule

`default_nettype wire

/* File: bench/stdp_chk_asserts.sv */
// Purpose: Port checker
// Assumes: Sync reset
// Notes:   Bound below
`timescale 1ns/100ps
`default_nettype none
module stdp_chk
  import stdp_pkg::*;
(
  input wire logic      clk_in, rst_n_in, transmit_strobe_in, chip_select_low_n_in,
  input wire stdp_cfg_t cfg_in,
  input wire logic      tx_active_out, tx_bit_valid_out, packet_bypass_out, pin_a_oe_out,
  input wire logic      pin_b_oe_out
);
  wire logic [1:0] f = cfg_in.packet_format_select;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_byp; f[0] |=> packet_bypass_out; endproperty
  a_byp: assert property (p_byp) else $error("no bypass");
  property p_nbyp; !f[0] |=> !packet_bypass_out; endproperty
  a_nbyp: assert property (p_nbyp) else $error("bypass");
  property p_go; transmit_strobe_in && !tx_active_out && f[0] |=> tx_active_out; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_ref; transmit_strobe_in && !tx_active_out && !f[0] |=> !tx_active_out; endproperty
  a_ref: assert property (p_ref) else $error("bad start");
  property p_pa; tx_active_out [*2] |-> !pin_a_oe_out; endproperty
  a_pa: assert property (p_pa) else $error("pin a driven");
  property p_pb; !chip_select_low_n_in [*4] |-> !pin_b_oe_out; endproperty
  a_pb: assert property (p_pb) else $error("pin b driven");
  property p_idle; !tx_active_out [*2] |-> !tx_bit_valid_out; endproperty
  a_idle: assert property (p_idle) else $error("idle bit");
  property p_as; tx_bit_valid_out && f == STDP_FMT_ASYNC && cfg_in.rate_div == 16'h0000
    |=> tx_bit_valid_out || !tx_active_out; endproperty
  a_as: assert property (p_as) else $error("async tick");
  property p_sy; tx_bit_valid_out && f == STDP_FMT_SYNC |=> !tx_bit_valid_out [*7]; endproperty
  a_sy: assert property (p_sy) else $error("sync tick");
  c_as: cover property (tx_bit_valid_out && f == STDP_FMT_ASYNC);
  c_sy: cover property (tx_bit_valid_out && f == STDP_FMT_SYNC);
  c_rf: cover property (transmit_strobe_in && !f[0]);
endmodule
bind stdp_serial_tx_data_port stdp_chk u_chk (
  .clk_in               (clk_in),
  .rst_n_in             (rst_n_in),
  .transmit_strobe_in   (transmit_strobe_in),
  .chip_select_low_n_in (chip_select_low_n_in),
  .cfg_in               (cfg_in),
  .tx_active_out        (tx_active_out),
  .tx_bit_valid_out     (tx_bit_valid_out),
  .packet_bypass_out    (packet_bypass_out),
  .pin_a_oe_out         (pin_a_oe_out),
  .pin_b_oe_out         (pin_b_oe_out)
);
`default_nettype wire

/* File: bench/stdp_host.sv */
// Purpose: Host bit source
// Assumes: Bit clock on pin C
// Notes:   Toggles when released
`timescale 1ns/100ps
`default_nettype none
module stdp_host (
  input wire logic clk_in, sync_in, active_in, bit_clk_in,
  output var logic data_out = 1'b0,
  output var logic rise_out = 1'b0
);
  integer seed = 32'hD40C1757;
  logic   ck_q = 1'b0;
  int     n = 0;
  always @(posedge clk_in) begin
    ck_q <= bit_clk_in;
    rise_out <= sync_in && active_in && !ck_q && bit_clk_in;
    n <= active_in ? n + 1 : 0;
    if (!active_in) data_out <= ~data_out;
    else if (sync_in ? (ck_q && !bit_clk_in) : (n % 8 == 0)) begin
      data_out <= 1'($random(seed));
    end
  end
endmodule
`default_nettype wire

/* File: bench/stdp_serial_tx_data_port_tb_top.sv */
// Purpose: Bench top
// Assumes: 50 MHz clock
// Notes:   Rate divider zero
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin \
  n_compared++; \
  if ((e) !== (s)) begin \
    bad_count++; \
    $display("BAD %s exp %0h got %0h", n, e, s); \
  end \
end
module stdp_serial_tx_data_port_tb_top;
  import stdp_pkg::*;
  logic clk_in = 0, rst_n_in = 0, transmit_strobe_in = 0, tx_stop_in = 0;
  logic chip_select_low_n_in = 1;
  logic pin_a_in, pin_a_out, pin_a_oe_out, pin_b_out, pin_b_oe_out, pin_c_out, pin_c_oe_out;
  logic tx_active_out, tx_bit_out, tx_bit_valid_out, packet_bypass_out, rise, e;
  stdp_cfg_t cfg_in = '0;
  int bad_count = 0, n_compared = 0;
  logic [7:0] hist = 8'h00;
  logic prev_valid_q = 1'b0;
  logic q[$];
  always #10 clk_in = ~clk_in;
  stdp_serial_tx_data_port dut (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .cfg_in               (cfg_in),
    .transmit_strobe_in   (transmit_strobe_in),
    .tx_stop_in           (tx_stop_in),
    .chip_select_low_n_in (chip_select_low_n_in),
    .pin_a_in             (pin_a_in),
    .pin_a_out            (pin_a_out),
    .pin_a_oe_out         (pin_a_oe_out),
    .pin_b_out            (pin_b_out),
    .pin_b_oe_out         (pin_b_oe_out),
    .pin_c_out            (pin_c_out),
    .pin_c_oe_out         (pin_c_oe_out),
    .tx_active_out        (tx_active_out),
    .tx_bit_out           (tx_bit_out),
    .tx_bit_valid_out     (tx_bit_valid_out),
    .packet_bypass_out    (packet_bypass_out)
  );
  stdp_host host (.clk_in, .sync_in(cfg_in.packet_format_select == STDP_FMT_SYNC),
    .active_in(tx_active_out), .bit_clk_in(pin_c_out), .data_out(pin_a_in), .rise_out(rise));
  // ========================================
  // Result watcher
  always @(posedge clk_in) begin
    hist <= {hist[6:0], pin_a_in};
    prev_valid_q <= tx_bit_valid_out;
    if (rise) q.push_back(pin_a_in);
    if (tx_bit_valid_out && cfg_in.packet_format_select == STDP_FMT_SYNC && q.size() > 8) begin
      e = q.pop_front();
      `CHK("sync bit", e, tx_bit_out)
    end
    if (tx_bit_valid_out && cfg_in.packet_format_select == STDP_FMT_ASYNC &&
        (hist == 8'h00 || hist == 8'hFF)) begin
      `CHK("async bit", hist[0], tx_bit_out)
      // Pins lag by one register, so skip the first tick of a run
      if (prev_valid_q) begin
        `CHK("pin b data", hist[0], pin_b_out)
        `CHK("pin c data", hist[0], pin_c_out)
      end
    end
  end
  task automatic go(input logic [1:0] f, input logic [5:0] c, input int n);
    q.delete();
    cfg_in <= '{f, STDP_SEL_SERIAL_CLK, STDP_SEL_SERIAL_DATA, c, 16'h0000};
    chip_select_low_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chip_select_low_n_in <= 1'b1;
    transmit_strobe_in <= 1'b1;
    @(posedge clk_in) transmit_strobe_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1 `CHK("active", f[0], tx_active_out)
    `CHK("pin a oe", !f[0], pin_a_oe_out)
    `CHK("pin b oe", 1'b1, pin_b_oe_out)
    `CHK("pin c oe", c != STDP_SEL_HIGH_Z, pin_c_oe_out)
    if (f != STDP_FMT_SYNC) `CHK("pin a level", 1'b0, pin_a_out)
    if (f != STDP_FMT_ASYNC) `CHK("pin b level", 1'b0, pin_b_out)
    @(posedge clk_in) tx_stop_in <= 1'b1;
    @(posedge clk_in) tx_stop_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic print_verdict;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    go(STDP_FMT_NORMAL, STDP_SEL_HIGH_Z, 40);
    go(2'h2, STDP_SEL_SERIAL_DATA, 40);
    go(STDP_FMT_ASYNC, STDP_SEL_SERIAL_DATA, 400);
    // Sync run: raw random stream, no sync word, checksum or length field
    go(STDP_FMT_SYNC, STDP_SEL_SERIAL_CLK, 900);
    print_verdict();
  end
endmodule
`default_nettype wire
